// ===== verilog/sec_lock_pkg.sv
// Constants and carrier types for the drive security lock state machine.
// Assumes one 20 MHz clock and a command layer that hands over decoded opcodes
// and a stream of 16-bit sector words.
// Summary of operation
// RQ1: Freeze command freezes at once, no data
// RQ2: Frozen rejects set, unlock, disable, erase commands
// RQ3: Only power cycle or sanitize leaves frozen
// RQ4: User password enables locking; lock after power-on
// RQ5: Master password stored, locking left unchanged
// RQ6: One sector: identifier, level bits, password words
// RQ7: All 32 password bytes stored and compared
// RQ8: Word 17 updates master code unless 0000h/FFFFh
// RQ9: Master code shown as identify word 92
// RQ10: High level: user or master password unlocks
// RQ11: Maximum level: only user password unlocks
// RQ12: Unlock keeps passwords; relocks after any reset
// RQ13: Master unlock compares at high, rejected at maximum
// RQ14: User unlock compares with stored user password
// RQ15: Mismatch aborts, decrements counter starting at five
// RQ16: Exhausted counter rejects protected commands until reset
// RQ17: User unlock with locking disabled aborts
// RQ18: Abort after data means password mismatch only; code also sets it for refused unlocks (locking disabled, master at maximum)
// RQ19: Set password and unlock take one sector
// RQ20: Erase prepare while frozen aborts
// RQ21: Rejections abort with no state changed
package sec_lock_pkg;
   localparam logic [7:0] CMD_SET_PASSWORD = 8'hF1;
   localparam logic [7:0] CMD_UNLOCK = 8'hF2;
   localparam logic [7:0] CMD_ERASE_PREPARE = 8'hF3;
   localparam logic [7:0] CMD_ERASE_UNIT = 8'hF4;
   localparam logic [7:0] CMD_FREEZE = 8'hF5;
   localparam logic [7:0] CMD_DISABLE_PASSWORD = 8'hF6;

   // Sector layout, in 16-bit words
   localparam logic [7:0] WORD_CONTROL = 8'h00;
   localparam logic [7:0] WORD_PWD_FIRST = 8'h01;
   localparam logic [7:0] WORD_PWD_LAST = 8'h10;
   localparam logic [7:0] WORD_MASTER_CODE = 8'h11;
   localparam logic [7:0] WORD_SECTOR_LAST = 8'hFF;
   localparam int BIT_IDENTIFIER = 0;
   localparam int BIT_LEVEL = 8;
   localparam int PWD_BITS = 256;

   localparam logic [15:0] CODE_NONE_LOW = 16'h0000;
   localparam logic [15:0] CODE_NONE_HIGH = 16'hFFFF;
   // Reset value of the stored master code; value is arbitrary
   localparam logic [15:0] MASTER_CODE_RESET = 16'hFFFE;

   localparam logic [2:0] ATTEMPTS_RESET = 3'h5;

   typedef enum logic {LEVEL_HIGH, LEVEL_MAX} level_t;

   // Security state seen by the rest of the drive
   typedef struct packed {
      logic locking_enabled;
      logic locked;
      logic frozen;
      level_t level;
      logic exhausted;
      logic [2:0] attempts_left;
   } sec_status_t;

   // Completion of one command
   typedef struct packed {
      logic done;
      logic abort_err;
      logic err_status;
      logic after_data;
   } completion_t;
endpackage : sec_lock_pkg

// ===== verilog/drive_security_lock_fsm.sv
// Security lock command interpreter for a disk drive.
// Assumes opcodes arrive already decoded on a valid/ready port, and that the
// host sends exactly 256 words once data_request is raised.
`timescale 1ns/1ps
module drive_security_lock_fsm (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic power_cycle,
   input wire logic hard_reset,
   input wire logic sanitize_done,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic cmd_ready,
   output logic data_request,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   output sec_lock_pkg::completion_t completion,
   output sec_lock_pkg::sec_status_t status,
   output logic [15:0] identify_word92
);

   typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_EVAL} state_t;

   state_t state;
   logic [7:0] cmd_held;
   logic [7:0] word_index;
   logic ctrl_master;
   logic ctrl_max;
   logic [15:0] code_word;
   logic [sec_lock_pkg::PWD_BITS-1:0] pwd_buf;
   logic [sec_lock_pkg::PWD_BITS-1:0] user_pwd;
   logic [sec_lock_pkg::PWD_BITS-1:0] master_pwd;
   logic [15:0] master_code;
   logic locking_enabled;
   logic locked;
   logic frozen;
   sec_lock_pkg::level_t level;
   logic [2:0] attempts;

   // Protected commands; all share the frozen and exhausted checks
   function automatic logic is_protected(input logic [7:0] code);
      is_protected = (code == sec_lock_pkg::CMD_SET_PASSWORD) ||
                     (code == sec_lock_pkg::CMD_UNLOCK) ||
                     (code == sec_lock_pkg::CMD_DISABLE_PASSWORD) ||
                     (code == sec_lock_pkg::CMD_ERASE_PREPARE) ||
                     (code == sec_lock_pkg::CMD_ERASE_UNIT);
   endfunction : is_protected

   // Commands that carry one data sector
   function automatic logic takes_sector(input logic [7:0] code);
      takes_sector = (code == sec_lock_pkg::CMD_SET_PASSWORD) ||
                     (code == sec_lock_pkg::CMD_UNLOCK);
   endfunction : takes_sector

   wire logic exhausted = (attempts == 3'h0);
   wire logic accept_cmd = cmd_valid && (state == ST_IDLE);
   wire logic accept_word = word_valid && (state == ST_XFER);
   wire logic last_word = accept_word && (word_index == sec_lock_pkg::WORD_SECTOR_LAST);

   // Early rejection, before any data phase
   wire logic reject_frozen = frozen && is_protected(cmd_code); // RQ2 RQ20
   wire logic reject_spent = exhausted && is_protected(cmd_code); // RQ16
   // Setting a password while locked is refused, as a locked drive must be unlocked first
   wire logic reject_locked = locked && (cmd_code == sec_lock_pkg::CMD_SET_PASSWORD);
   // Only freeze, erase prepare, set password and unlock are carried out here
   wire logic known = (cmd_code == sec_lock_pkg::CMD_FREEZE) ||
                      (cmd_code == sec_lock_pkg::CMD_ERASE_PREPARE) ||
                      takes_sector(cmd_code);
   wire logic early_abort = reject_frozen || reject_spent || reject_locked || !known; // RQ21
   wire logic start_xfer = accept_cmd && !early_abort && takes_sector(cmd_code); // RQ19
   wire logic quick_done = accept_cmd && (early_abort || !takes_sector(cmd_code));
   wire logic do_freeze = accept_cmd && !early_abort &&
                          (cmd_code == sec_lock_pkg::CMD_FREEZE); // RQ1

   // Evaluation of a received sector; full 256-bit compares
   wire logic user_match = (pwd_buf == user_pwd); // RQ7 RQ14
   wire logic master_match = (pwd_buf == master_pwd); // RQ7
   wire logic is_set = (cmd_held == sec_lock_pkg::CMD_SET_PASSWORD);
   wire logic is_unlock = (cmd_held == sec_lock_pkg::CMD_UNLOCK);
   wire logic unlock_disabled_user = is_unlock && !ctrl_master && !locking_enabled; // RQ17
   wire logic unlock_master_max = is_unlock && ctrl_master &&
                                  (level == sec_lock_pkg::LEVEL_MAX); // RQ11 RQ13
   wire logic unlock_match = ctrl_master ? master_match : user_match; // RQ10 RQ13 RQ14
   wire logic unlock_refused = unlock_disabled_user || unlock_master_max;
   wire logic unlock_fail = is_unlock && !unlock_refused && !unlock_match; // RQ15 RQ18
   wire logic unlock_ok = is_unlock && !unlock_refused && unlock_match;
   wire logic eval_abort = unlock_refused || unlock_fail;
   wire logic code_valid = (code_word != sec_lock_pkg::CODE_NONE_LOW) &&
                           (code_word != sec_lock_pkg::CODE_NONE_HIGH); // RQ8
   wire logic eval_now = (state == ST_EVAL);

   // Either reset event restores the counter and relocks an enabled drive
   wire logic any_reset = power_cycle || hard_reset;

   // Command sequencer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_xfer) begin
                  state <= ST_XFER;
               end
            end
            ST_XFER: begin
               if (last_word) begin
                  state <= ST_EVAL;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Latch the opcode and count sector words
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cmd_held <= 8'h00;
         word_index <= 8'h00;
      end else begin
         if (accept_cmd) begin
            cmd_held <= cmd_code;
         end
         if (start_xfer) begin
            word_index <= 8'h00;
         end else if (accept_word) begin
            word_index <= word_index + 8'h01;
         end
      end
   end

   // Pick apart the sector: control word, password, master code word
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_master <= 1'b0;
         ctrl_max <= 1'b0;
         code_word <= 16'h0000;
         pwd_buf <= '0;
      end else if (accept_word) begin
         if (word_index == sec_lock_pkg::WORD_CONTROL) begin
            ctrl_master <= word_data[sec_lock_pkg::BIT_IDENTIFIER]; // RQ6
            ctrl_max <= word_data[sec_lock_pkg::BIT_LEVEL]; // RQ6
         end
         if ((word_index >= sec_lock_pkg::WORD_PWD_FIRST) &&
             (word_index <= sec_lock_pkg::WORD_PWD_LAST)) begin
            pwd_buf <= {pwd_buf[sec_lock_pkg::PWD_BITS-17:0], word_data}; // RQ7
         end
         if (word_index == sec_lock_pkg::WORD_MASTER_CODE) begin
            code_word <= word_data;
         end
      end
   end

   // Stored passwords and master identifier code survive hard and power resets
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         user_pwd <= '0;
         master_pwd <= '0;
         master_code <= sec_lock_pkg::MASTER_CODE_RESET;
      end else if (eval_now && is_set) begin
         if (ctrl_master) begin
            master_pwd <= pwd_buf; // RQ5
            if (code_valid) begin
               master_code <= code_word; // RQ8
            end
         end else begin
            user_pwd <= pwd_buf; // RQ10 RQ11
         end
      end
   end

   // Locking enable and security level, set by a user password only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         locking_enabled <= 1'b0;
         level <= sec_lock_pkg::LEVEL_HIGH;
      end else if (eval_now && is_set && !ctrl_master) begin
         locking_enabled <= 1'b1; // RQ4
         level <= ctrl_max ? sec_lock_pkg::LEVEL_MAX : sec_lock_pkg::LEVEL_HIGH; // RQ10 RQ11
      end
   end

   // Lock takes effect only at a reset event; unlock clears it at once
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         locked <= 1'b0;
      end else if (any_reset) begin
         locked <= locking_enabled; // RQ4 RQ12
      end else if (eval_now && unlock_ok) begin
         locked <= 1'b0; // RQ12
      end
   end

   // Frozen ends only by a power cycle or a finished sanitize
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         frozen <= 1'b0;
      end else if (do_freeze) begin
         frozen <= 1'b1; // RQ1
      end else if (power_cycle || sanitize_done) begin
         frozen <= 1'b0; // RQ3
      end
   end

   // Failed unlock counter; a reset in the same cycle as a miss wins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         attempts <= sec_lock_pkg::ATTEMPTS_RESET;
      end else if (any_reset) begin
         attempts <= sec_lock_pkg::ATTEMPTS_RESET; // RQ16
      end else if (eval_now && unlock_fail && !exhausted) begin
         attempts <= attempts - 3'h1; // RQ15
      end
   end

   // Completion is a one-cycle pulse; abort carries both error bits
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         completion <= '0;
      end else begin
         completion.done <= quick_done || eval_now;
         completion.abort_err <= (quick_done && early_abort) || (eval_now && eval_abort); // RQ21
         completion.err_status <= (quick_done && early_abort) || (eval_now && eval_abort);
         completion.after_data <= eval_now && eval_abort; // RQ18
      end
   end

   // Handshake outputs are combinational
   assign cmd_ready = (state == ST_IDLE);
   assign data_request = (state == ST_XFER); // RQ19

   // Status view built in one assignment so the struct has a single driver
   assign status = {locking_enabled, locked, frozen, level, exhausted, attempts};
   assign identify_word92 = master_code; // RQ9

endmodule : drive_security_lock_fsm

// ===== verification/drive_security_lock_fsm_sva.sv
// Port assertions for the security lock command interpreter.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module drive_security_lock_fsm_sva (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic power_cycle,
   input wire logic hard_reset,
   input wire logic sanitize_done,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_ready,
   input wire logic data_request,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   input wire sec_lock_pkg::completion_t completion,
   input wire sec_lock_pkg::sec_status_t status,
   input wire logic [15:0] identify_word92
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Taken commands and the events that restore state
   wire tk = cmd_valid && cmd_ready;
   wire gated = tk && (cmd_code inside {[8'hF1:8'hF4], 8'hF6});
   wire rst_ev = power_cycle || hard_reset;
   logic [8:0] n;
   // Words taken in the current data phase
   always_ff @(posedge clock) begin
      if (!rst_n || !data_request) n <= 9'h000;
      else if (word_valid) n <= n + 9'h001;
   end
   a_freeze_enters: assert property (tk && cmd_code == 8'hF5
      |=> completion.done && !completion.abort_err && status.frozen) else $error("no freeze");
   a_frozen_rejects: assert property (status.frozen && gated && !power_cycle
      && !sanitize_done |=> completion.abort_err && !completion.after_data)
      else $error("frozen accepted");
   a_frozen_holds: assert property (status.frozen && !power_cycle && !sanitize_done
      |=> status.frozen) else $error("frozen lost");
   a_lock_cause: assert property ($rose(status.locked) |-> $past(rst_ev))
      else $error("lock without reset");
   a_sector_len: assert property ($fell(data_request) && $past(rst_n) |-> n == 9'h100)
      else $error("sector length");
   a_request_cause: assert property ($rose(data_request)
      |-> $past(tk && cmd_code inside {8'hF1, 8'hF2})) else $error("stray data request");
   a_count_steps: assert property ($changed(status.attempts_left) && $past(rst_n)
      |-> $past(rst_ev) && status.attempts_left == 3'h5 || completion.after_data
      && status.attempts_left == $past(status.attempts_left) - 3'h1) else $error("counter");
   a_exhausted_rejects: assert property (status.exhausted && gated && !rst_ev
      |=> completion.abort_err && !completion.after_data) else $error("exhausted accepted");
   a_code_valid: assert property (identify_word92 != 16'h0000
      && identify_word92 != 16'hFFFF) else $error("bad identifier code");
   a_abort_marks: assert property (completion.abort_err || completion.after_data
      |-> completion.done && completion.err_status && completion.abort_err)
      else $error("abort flags");
   a_ready_busy: assert property (data_request |-> !cmd_ready)
      else $error("ready during data phase");
   c_freeze: cover property (tk && cmd_code == 8'hF5);
   c_unlocked: cover property ($fell(status.locked) && !rst_ev);
   c_mismatch: cover property (completion.done && completion.after_data);
   c_exhausted: cover property (status.exhausted);
endmodule : drive_security_lock_fsm_sva
bind drive_security_lock_fsm drive_security_lock_fsm_sva u_sva (.clock(clock), .rst_n(rst_n),
   .power_cycle(power_cycle), .hard_reset(hard_reset), .sanitize_done(sanitize_done),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
   .data_request(data_request), .word_valid(word_valid), .word_data(word_data),
   .completion(completion), .status(status), .identify_word92(identify_word92));

// ===== verification/host_sector_model.sv
// Host side of the data phase: sends one 256-word sector per request.
// Assumes the bench holds ctrl, pwd and mcode steady during a transfer.
`timescale 1ns/1ps
module host_sector_model (
   input wire logic clock,
   input wire logic slow,
   input wire logic data_request,
   input wire logic [15:0] ctrl,
   input wire logic [255:0] pwd,
   input wire logic [15:0] mcode,
   output logic word_valid = 1'b0,
   output logic [15:0] word_data = 16'h0000
);
   logic [8:0] idx = 9'h000;
   logic gap = 1'b0;
   // Sector layout, first password word most significant
   wire [15:0] w = idx == 9'h000 ? ctrl : idx <= 9'h010 ? pwd[16*(17-idx)-1 -: 16]
      : idx == 9'h011 ? mcode : {7'h00, idx};
   // Word index advances on each word the device takes
   always @(posedge clock) begin
      if (!data_request) idx <= 9'h000;
      else if (word_valid) idx <= idx + 9'h001;
   end
   // Slow mode idles every other cycle; an idle line shows inverted data
   always @(negedge clock) begin
      gap <= slow && !gap;
      word_valid <= data_request && idx < 9'h100 && !gap;
      word_data <= (data_request && !gap) ? w : ~word_data;
   end
endmodule : host_sector_model

// ===== verification/drive_security_lock_fsm_bench.sv
// Self-checking bench for the security lock command interpreter.
// Assumes the host model answers every data phase with a whole sector.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end
module drive_security_lock_fsm_bench;
   logic clock = 1'b0, rst_n, cmd_valid, slow, word_valid, cmd_ready, data_request;
   logic [2:0] ev;
   logic [7:0] cmd_code;
   logic [7:0] fz [5] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6};
   logic [15:0] ctrl, mc, e92, word_data, identify_word92;
   logic [15:0] r = 16'h0008;
   logic [255:0] pwd, pu, pm;
   sec_lock_pkg::completion_t completion;
   sec_lock_pkg::sec_status_t status;
   int fail_count = 0, checks_done = 0;
   drive_security_lock_fsm u_drive_security_lock_fsm (.clock(clock), .rst_n(rst_n),
      .power_cycle(ev[2]), .hard_reset(ev[1]), .sanitize_done(ev[0]), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_ready(cmd_ready), .data_request(data_request),
      .word_valid(word_valid), .word_data(word_data), .completion(completion),
      .status(status), .identify_word92(identify_word92));
   host_sector_model u_host_sector_model (.clock(clock), .slow(slow),
      .data_request(data_request), .ctrl(ctrl), .pwd(pwd), .mcode(mc),
      .word_valid(word_valid), .word_data(word_data));
   // 50 ns period
   initial begin
      forever #25 clock = ~clock;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Codes 0000h and FFFFh leave the stored identifier alone
   function automatic logic [15:0] exp92(input logic [15:0] old, input logic [15:0] nw);
      return (nw == 16'h0000 || nw == 16'hFFFF) ? old : nw;
   endfunction : exp92
   task automatic fill(output logic [255:0] v);
      for (int k = 0; k < 16; k++) begin
         r = lfsr(r);
         v[16*k +: 16] = r;
      end
   endtask : fill
   // One-cycle event pulse, effect settled on return
   task automatic pulse(input logic [2:0] e);
      ev = e;
      @(negedge clock);
      ev = 3'b000;
      @(negedge clock);
   endtask : pulse
   // Offer a command, wait for completion, compare {abort, after data}
   task automatic cmd(input logic [7:0] c, input logic [15:0] ct, input logic [255:0] p,
      input logic [1:0] ex);
      int i;
      ctrl = ct;
      pwd = p;
      cmd_code = c;
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      i = 0;
      while (completion.done !== 1'b1 && i < 900) begin
         @(negedge clock);
         i++;
      end
      `CHK("abort", ex, {completion.abort_err, completion.after_data})
      @(negedge clock);
   endtask : cmd
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   // Watchdog sized well above the longest sequence
   initial begin
      repeat (40000) @(posedge clock);
      fail_count++;
      conclude;
   end
   initial begin
      {cmd_valid, slow, rst_n, ev, cmd_code, ctrl, mc, pwd} = '0;
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      `CHK("tries", 3'h5, status.attempts_left)
      fill(pu);
      fill(pm);
      r = lfsr(r);
      mc = r;
      e92 = exp92(sec_lock_pkg::MASTER_CODE_RESET, mc);
      cmd(8'hF2, 16'h0000, pu, 2'b11);
      cmd(8'hF1, 16'h0001, pm, 2'b00);
      `CHK("id92", e92, identify_word92)
      mc = 16'hFFFF;
      cmd(8'hF1, 16'h0001, pm, 2'b00);
      `CHK("id92", exp92(e92, mc), identify_word92)
      pulse(3'b100);
      `CHK("lock", 2'b00, {status.locking_enabled, status.locked})
      slow = 1'b1;
      cmd(8'hF1, 16'h0000, pu, 2'b00);
      `CHK("lock", 2'b10, {status.locking_enabled, status.locked})
      pulse(3'b100);
      `CHK("lock", 2'b11, {status.locking_enabled, status.locked})
      cmd(8'hF2, 16'h0000, pu ^ 256'h1, 2'b11);
      `CHK("tries", 3'h4, status.attempts_left)
      cmd(8'hF2, 16'h0001, pm, 2'b00);
      `CHK("lock", 2'b10, {status.locking_enabled, status.locked})
      pulse(3'b010);
      `CHK("tries lock", 4'hD, {status.locked, status.attempts_left})
      cmd(8'hF2, 16'h0000, pu, 2'b00);
      cmd(8'hF1, 16'h0100, pu, 2'b00);
      `CHK("level", 1'b1, status.level)
      pulse(3'b100);
      cmd(8'hF2, 16'h0001, pm, 2'b11);
      pulse(3'b010);
      slow = 1'b0;
      repeat (5) cmd(8'hF2, 16'h0000, pu ^ 256'h1, 2'b11);
      `CHK("exhausted", 4'h8, {status.exhausted, status.attempts_left})
      cmd(8'hF2, 16'h0000, pu, 2'b10);
      pulse(3'b010);
      cmd(8'hF2, 16'h0000, pu, 2'b00);
      cmd(8'hF5, 16'h0000, pu, 2'b00);
      foreach (fz[k]) cmd(fz[k], 16'h0000, pu, 2'b10);
      pulse(3'b010);
      `CHK("frozen", 1'b1, status.frozen)
      pulse(3'b001);
      `CHK("frozen", 1'b0, status.frozen)
      cmd(8'hF5, 16'h0000, pu, 2'b00);
      pulse(3'b100);
      `CHK("frozen", 1'b0, status.frozen)
      cmd(8'h3C, 16'h0000, pu, 2'b10);
      conclude;
   end
endmodule : drive_security_lock_fsm_bench
